// ---- src/global_status_map.vh ----
`ifndef GLOBAL_STATUS_MAP_VH
`define GLOBAL_STATUS_MAP_VH

// ------------------------------------------------------------
// register offsets (byte addresses on the 8-bit address port)
// ------------------------------------------------------------
`define ADDR_W 8
`define DATA_W 16
`define OFS_SUMMARY_STATUS 8'h10
`define OFS_SUMMARY_IRQ_EN 8'h12
`define OFS_STATUS_LIVE 8'h14
`define OFS_STATUS_LATCHED 8'h16
`define OFS_STATUS_IRQ_EN 8'h18
`define OFS_GP_PIN_READBACK 8'h1C
`define OFS_GLOBAL_CONTROL 8'h1E

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define BIT_UPDATE_DONE 0
`define BIT_LOCK_LOST 1
`define BIT_ONE_SECOND 2
`define BIT_ADAPTER_REF_CLOCK_PIN_ACT 3
`define BIT_REF8K_ACT 4
`define BIT_SUMMARY 0
`define BIT_REF8K_SELECT 0
`define LATCH_W 5
`define IRQ_EN_W 3
`define GPIO_W 8
`define GPIO_REF8K_IDX 3
`define NUM_PORTS 4
`define NUM_PLLS 3

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define RST_DATA 16'h0000
`define RST_LATCH 5'h00
`define RST_IRQ_EN 3'h0
`define RST_GPIO 8'h00
`define RST_PORTS 4'h0

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define CLK_PERIOD_NS 25
`define ONE_SECOND_NS 1000000000
`define TICK_CNT_W 32

`endif

// ---- src/pin_sync_edge.v ----
`timescale 1ns/100ps
// two-stage synchroniser bank with rising-edge pulses
module pin_sync_edge #(
  parameter W = 9
) (
  // clock and reset
  input wire i_clk,
  input wire i_resetn,
  input wire i_ce,
  // asynchronous pins
  input wire [W-1:0] i_pins,
  // synchronised results
  output reg [W-1:0] o_level,
  output reg [W-1:0] o_rise
);

  reg [W-1:0] meta_q;
  reg [W-1:0] prev_q;

  // ------------------------------------------------------------
  // sync stages
  // ------------------------------------------------------------
  // first stage feeds only the second; edges taken from stage two
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      meta_q <= {W{1'b0}};
      o_level <= {W{1'b0}};
      prev_q <= {W{1'b0}};
      o_rise <= {W{1'b0}};
    end else if (i_ce) begin
      meta_q <= i_pins;
      o_level <= meta_q;
      prev_q <= o_level;
      o_rise <= o_level & ~prev_q;
    end
  end

endmodule

// ---- src/global_status_interrupt_tree.v ----
`timescale 1ns/100ps
`include "global_status_map.vh"
// Summary of operation
// - live update-done is the AND of update-done of every port set for global update control.
// - the 8 kHz activity latch sets on activity of gp pin 4, only while the 8 kHz select bit is set.
// - the reference clock activity latch sets on activity of the adapter reference clock pin.
// - the one-second latch sets once per second and, when enabled, raises the summary bit.
// - the lock-lost latch sets on each rising edge of the live lock-lost bit.
// - an enabled, set lock-lost latch raises the summary bit and, with summary enable, pulls the pin low.
// - the update-done latch sets on each rising edge of live update-done.
// - an enabled, set update-done latch raises the summary bit and, with summary enable, pulls the pin low.
// - the one-second enable sits in bit 2; one lets the one-second latch reach the pin, zero blocks it.
// - every bit of the latched-status enable register resets to zero.
// - the pin read-back register shows the eight gp pin levels in bits 7..0, pin 1 in bit 0.
// - the summary bit is set while any enabled latched bit is set; with summary enable the pin goes low.
// - live lock-lost is high while any adapter pll is unlocked.
module global_status_interrupt_tree #(
  parameter ONE_SEC_CYCLES = `ONE_SECOND_NS / `CLK_PERIOD_NS
) (
  // clock, reset, enable
  input wire i_clk,
  input wire i_resetn,
  input wire i_ce,
  // register port
  input wire [`ADDR_W-1:0] i_addr,
  input wire [`DATA_W-1:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [`DATA_W-1:0] o_rdata,
  // per-port monitor update status, same clock
  input wire [`NUM_PORTS-1:0] i_port_update_done,
  input wire [`NUM_PORTS-1:0] i_monitor_update_mode_select,
  // clock adapter pll lock, same clock
  input wire [`NUM_PLLS-1:0] i_pll_unlocked,
  // pins from outside
  input wire [`GPIO_W-1:0] i_gp_pins,
  input wire i_adapter_ref_clock_pin,
  // interrupt and status outputs
  output reg o_irq_n,
  output reg o_ref8k_input_select,
  output reg o_global_update_done
);

  // ------------------------------------------------------------
  // functions
  // ------------------------------------------------------------
  // write-one-to-clear with set priority over clear
  function [`LATCH_W-1:0] sticky_next;
    input [`LATCH_W-1:0] cur;
    input [`LATCH_W-1:0] set;
    input [`LATCH_W-1:0] clr;
    begin
      sticky_next = (cur & ~clr) | set;
    end
  endfunction

  // summary term from latches and enables
  function summary_of;
    input [`LATCH_W-1:0] lat;
    input [`IRQ_EN_W-1:0] en;
    begin
      summary_of = |(lat[`IRQ_EN_W-1:0] & en);
    end
  endfunction

  // ------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------
  localparam [`TICK_CNT_W-1:0] TICK_LAST = ONE_SEC_CYCLES - 1;

  wire [`GPIO_W:0] pin_level;
  wire [`GPIO_W:0] pin_rise;
  wire [`GPIO_W-1:0] gpio_level;
  wire adapter_ref_clock_pin_rise;
  wire ref8k_rise;

  reg [`LATCH_W-1:0] latch_q;
  reg [`LATCH_W-1:0] latch_d;
  reg [`LATCH_W-1:0] latch_set;
  reg [`LATCH_W-1:0] latch_clr;
  reg [`IRQ_EN_W-1:0] irq_en_q;
  reg [`IRQ_EN_W-1:0] irq_en_d;
  reg summary_en_q;
  reg summary_en_d;
  reg ref8k_sel_d;
  reg update_done_d;
  reg update_done_prev_q;
  reg lock_lost_q;
  reg lock_lost_prev_q;
  reg [`TICK_CNT_W-1:0] tick_cnt_q;
  reg tick_pulse_q;
  reg summary_d;
  reg [`DATA_W-1:0] rdata_d;

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  // activity is taken as a sampled rising edge; a reference clock
  // above half the system clock may alias and be missed at times
  pin_sync_edge #(
    .W(`GPIO_W + 1)
  ) u_pin_sync (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_ce(i_ce),
    .i_pins({i_adapter_ref_clock_pin, i_gp_pins}),
    .o_level(pin_level),
    .o_rise(pin_rise)
  );

  assign gpio_level = pin_level[`GPIO_W-1:0];
  assign adapter_ref_clock_pin_rise = pin_rise[`GPIO_W];
  assign ref8k_rise = pin_rise[`GPIO_REF8K_IDX];

  // ------------------------------------------------------------
  // live status
  // ------------------------------------------------------------
  // and over ports in global mode; no port in global mode reads zero
  always @* begin
    update_done_d = (|i_monitor_update_mode_select) &&
      (&(i_port_update_done | ~i_monitor_update_mode_select));
  end

  // live bits and their previous values for edge detection
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_global_update_done <= 1'b0;
      update_done_prev_q <= 1'b0;
      lock_lost_q <= 1'b0;
      lock_lost_prev_q <= 1'b0;
    end else if (i_ce) begin
      o_global_update_done <= update_done_d;
      update_done_prev_q <= o_global_update_done;
      lock_lost_q <= |i_pll_unlocked;
      lock_lost_prev_q <= lock_lost_q;
    end
  end

  // ------------------------------------------------------------
  // one-second tick
  // ------------------------------------------------------------
  // free-running divider; shorten ONE_SEC_CYCLES in simulation
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      tick_cnt_q <= {`TICK_CNT_W{1'b0}};
      tick_pulse_q <= 1'b0;
    end else if (i_ce) begin
      if (tick_cnt_q == TICK_LAST) begin
        tick_cnt_q <= {`TICK_CNT_W{1'b0}};
        tick_pulse_q <= 1'b1;
      end else begin
        tick_cnt_q <= tick_cnt_q + 1'b1;
        tick_pulse_q <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // latch sources and host clears
  // ------------------------------------------------------------
  always @* begin
    latch_set = `RST_LATCH;
    latch_set[`BIT_UPDATE_DONE] = o_global_update_done & ~update_done_prev_q;
    latch_set[`BIT_LOCK_LOST] = lock_lost_q & ~lock_lost_prev_q;
    latch_set[`BIT_ONE_SECOND] = tick_pulse_q;
    latch_set[`BIT_ADAPTER_REF_CLOCK_PIN_ACT] = adapter_ref_clock_pin_rise;
    latch_set[`BIT_REF8K_ACT] = ref8k_rise & o_ref8k_input_select;
    latch_clr = `RST_LATCH;
    if (i_wr && i_addr == `OFS_STATUS_LATCHED) begin
      latch_clr = i_wdata[`LATCH_W-1:0];
    end
    // a set in the clearing cycle survives
    latch_d = sticky_next(latch_q, latch_set, latch_clr);
  end

  // ------------------------------------------------------------
  // writable registers
  // ------------------------------------------------------------
  always @* begin
    irq_en_d = irq_en_q;
    summary_en_d = summary_en_q;
    ref8k_sel_d = o_ref8k_input_select;
    if (i_wr) begin
      case (i_addr)
        `OFS_STATUS_IRQ_EN: begin
          irq_en_d = i_wdata[`IRQ_EN_W-1:0];
        end
        `OFS_SUMMARY_IRQ_EN: begin
          summary_en_d = i_wdata[`BIT_SUMMARY];
        end
        `OFS_GLOBAL_CONTROL: begin
          ref8k_sel_d = i_wdata[`BIT_REF8K_SELECT];
        end
        default: begin
          irq_en_d = irq_en_q;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // summary and interrupt
  // ------------------------------------------------------------
  // summary follows the registered latches and enables combinationally
  always @* begin
    summary_d = summary_of(latch_q, irq_en_q);
  end

  // state flops; pin computed from next values so it tracks the latches
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      latch_q <= `RST_LATCH;
      irq_en_q <= `RST_IRQ_EN;
      summary_en_q <= 1'b0;
      o_ref8k_input_select <= 1'b0;
      o_irq_n <= 1'b1;
    end else if (i_ce) begin
      latch_q <= latch_d;
      irq_en_q <= irq_en_d;
      summary_en_q <= summary_en_d;
      o_ref8k_input_select <= ref8k_sel_d;
      // active low; releases once no enabled latch remains
      o_irq_n <= ~(summary_of(latch_d, irq_en_d) & summary_en_d);
    end
  end

  // ------------------------------------------------------------
  // read path
  // ------------------------------------------------------------
  // unmapped offsets and reserved bits read zero
  always @* begin
    rdata_d = `RST_DATA;
    case (i_addr)
      `OFS_SUMMARY_STATUS: begin
        rdata_d[`BIT_SUMMARY] = summary_d;
      end
      `OFS_SUMMARY_IRQ_EN: begin
        rdata_d[`BIT_SUMMARY] = summary_en_q;
      end
      `OFS_STATUS_LIVE: begin
        rdata_d[`BIT_UPDATE_DONE] = o_global_update_done;
        rdata_d[`BIT_LOCK_LOST] = lock_lost_q;
      end
      `OFS_STATUS_LATCHED: begin
        rdata_d[`LATCH_W-1:0] = latch_q;
      end
      `OFS_STATUS_IRQ_EN: begin
        rdata_d[`IRQ_EN_W-1:0] = irq_en_q;
      end
      `OFS_GP_PIN_READBACK: begin
        rdata_d[`GPIO_W-1:0] = gpio_level;
      end
      `OFS_GLOBAL_CONTROL: begin
        rdata_d[`BIT_REF8K_SELECT] = o_ref8k_input_select;
      end
      default: begin
        rdata_d = `RST_DATA;
      end
    endcase
  end

  // read data stands only in the cycle after the strobe
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rdata <= `RST_DATA;
    end else if (i_ce) begin
      if (i_rd) begin
        o_rdata <= rdata_d;
      end else begin
        o_rdata <= `RST_DATA;
      end
    end
  end

endmodule

// ---- tb/gsit_checker.sv ----
`timescale 1ns/100ps
// ------------------------------
// port checker
// ------------------------------
module gsit_checker #(
  parameter ONE_SEC_CYCLES = 20
) (
  // clock, reset and register port
  input wire i_clk,
  input wire i_resetn,
  input wire i_ce,
  input wire [7:0] i_addr,
  input wire [15:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  input wire [15:0] o_rdata,
  // status sources
  input wire [3:0] i_port_update_done,
  input wire [3:0] i_monitor_update_mode_select,
  input wire [2:0] i_pll_unlocked,
  input wire [7:0] i_gp_pins,
  input wire i_adapter_ref_clock_pin,
  // outputs
  input wire o_irq_n,
  input wire o_ref8k_input_select,
  input wire o_global_update_done
);
  reg [2:0] en_q;
  reg sum_q;
  wire rd_go = i_ce && i_rd;
  wire wd0 = i_wdata[0];
  wire lock_now = |i_pll_unlocked;
  wire gud_now = (|i_monitor_update_mode_select) && (&(i_port_update_done | ~i_monitor_update_mode_select));
  wire mapped = i_addr inside {8'h10, 8'h12, 8'h14, 8'h16, 8'h18, 8'h1C, 8'h1E};
  // enable shadows; frozen with i_ce so they never run ahead of the design
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      en_q <= 3'h0;
      sum_q <= 1'b0;
    end else if (i_ce && i_wr) begin
      if (i_addr == 8'h18) en_q <= i_wdata[2:0];
      if (i_addr == 8'h12) sum_q <= i_wdata[0];
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  a_rdata_one_cycle: assert property ($past(i_ce) && !$past(i_rd) |-> o_rdata == 16'h0000)
    else $error("read data left standing");
  a_unmapped_zero: assert property (rd_go && !mapped |=> o_rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_irq_has_cause: assert property (!o_irq_n |-> sum_q && en_q != 3'h0)
    else $error("interrupt low without enabled source");
  a_enable_readback: assert property (rd_go && i_addr == 8'h18 |=> o_rdata == {13'h0000, en_q})
    else $error("enable register read wrong");
  a_summary_readback: assert property (rd_go && i_addr == 8'h12 |=> o_rdata == {15'h0000, sum_q})
    else $error("summary enable read wrong");
  a_update_and: assert property ($past(i_ce) && $past(i_resetn) |-> o_global_update_done == $past(gud_now))
    else $error("update done not the and of ports");
  a_live_read: assert property (rd_go && i_addr == 8'h14 && $past(i_resetn)
    |=> o_rdata == {14'h0000, $past(lock_now, 2), $past(o_global_update_done)})
    else $error("live status read wrong");
  a_pin_readback: assert property (rd_go && i_addr == 8'h1C && $past(i_resetn, 2)
    |=> o_rdata == {8'h00, $past(i_gp_pins, 3)})
    else $error("pin read-back wrong");
  a_select_write: assert property (i_ce && i_wr && i_addr == 8'h1E |=> o_ref8k_input_select == $past(wd0))
    else $error("select bit not written");
endmodule
bind global_status_interrupt_tree gsit_checker #(.ONE_SEC_CYCLES(ONE_SEC_CYCLES)) chk_u (
  .i_clk(i_clk), .i_resetn(i_resetn), .i_ce(i_ce), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
  .i_rd(i_rd), .o_rdata(o_rdata), .i_port_update_done(i_port_update_done),
  .i_monitor_update_mode_select(i_monitor_update_mode_select), .i_pll_unlocked(i_pll_unlocked),
  .i_gp_pins(i_gp_pins), .i_adapter_ref_clock_pin(i_adapter_ref_clock_pin), .o_irq_n(o_irq_n),
  .o_ref8k_input_select(o_ref8k_input_select), .o_global_update_done(o_global_update_done));

// ---- tb/host_model.sv ----
`timescale 1ns/100ps
// ------------------------------
// host bus master
// ------------------------------
module host_model (
  // clock
  input wire i_clk,
  // register bus towards the device
  output reg [7:0] o_addr,
  output reg [15:0] o_wdata,
  output reg o_wr,
  output reg o_rd
);
  // idle bus at time zero
  initial begin
    o_addr = 8'h00;
    o_wdata = 16'h0000;
    o_wr = 1'b0;
    o_rd = 1'b0;
  end
  // strobes are never lowered at the end, so back-to-back calls assign each signal once per edge
  task wr(input [7:0] a, input [15:0] d);
    begin
      o_addr <= a;
      o_wdata <= d;
      o_wr <= 1'b1;
      o_rd <= 1'b0;
      @(posedge i_clk);
    end
  endtask
  task rd(input [7:0] a);
    begin
      o_addr <= a;
      o_wr <= 1'b0;
      o_rd <= 1'b1;
      @(posedge i_clk);
    end
  endtask
  task idle(input integer n);
    begin
      o_wr <= 1'b0;
      o_rd <= 1'b0;
      repeat (n) @(posedge i_clk);
    end
  endtask
endmodule

// ---- tb/global_status_interrupt_tree_bench.sv ----
`timescale 1ns/100ps
// ------------------------------
// bench
// ------------------------------
module global_status_interrupt_tree_bench;
  reg clk, resetn, ce, adapter_ref_clock_pin, rd_q;
  reg [3:0] pdone, pmode;
  reg [2:0] unl;
  reg [7:0] gp;
  wire [7:0] addr;
  wire [15:0] wdata, rdata;
  wire wr, rd, irq_n, sel8k, gud;
  wire [1:0] obs = {gud, irq_n};
  integer error_cnt, n_checks, seed, cyc;
  logic [15:0] exp_q[$], msk_q[$];
  host_model host_u (.i_clk(clk), .o_addr(addr), .o_wdata(wdata), .o_wr(wr), .o_rd(rd));
  global_status_interrupt_tree #(.ONE_SEC_CYCLES(20)) dut_u (
    .i_clk(clk), .i_resetn(resetn), .i_ce(ce), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rdata(rdata), .i_port_update_done(pdone), .i_monitor_update_mode_select(pmode),
    .i_pll_unlocked(unl), .i_gp_pins(gp), .i_adapter_ref_clock_pin(adapter_ref_clock_pin), .o_irq_n(irq_n),
    .o_ref8k_input_select(sel8k), .o_global_update_done(gud));
  always #12.5 clk = ~clk;
  task check(input [15:0] seen, input [15:0] exp);
    begin
      n_checks = n_checks + 1;
      if (seen !== exp) begin
        error_cnt = error_cnt + 1;
        $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
      end
    end
  endtask
  task rd_exp(input [7:0] a, input [15:0] m, input [15:0] e);
    begin
      exp_q.push_back(e);
      msk_q.push_back(m);
      host_u.rd(a);
    end
  endtask
  // sampled at falling edges so the result never races the launching edge
  task wait_bit(input integer s, input e);
    integer k;
    begin
      host_u.idle(0);
      k = 0;
      @(negedge clk);
      while (obs[s] !== e && k < 30) begin
        @(negedge clk);
        k = k + 1;
      end
      check({15'h0000, obs[s]}, {15'h0000, e});
      @(posedge clk);
    end
  endtask
  task close_out;
    begin
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  // read monitor: oldest note against the cycle after each taken read
  always @(posedge clk) begin
    if (rd_q) check(rdata & msk_q.pop_front(), exp_q.pop_front());
    rd_q <= rd & ce;
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      error_cnt = error_cnt + 1;
      close_out;
    end
  end
  initial begin
    {clk, resetn, ce, adapter_ref_clock_pin, rd_q, pdone, pmode, unl, gp} = 0;
    {error_cnt, n_checks, cyc} = 0;
    seed = 32'h3cd8;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    ce <= 1'b1;
    rd_exp(8'h18, 16'hFFFF, 16'h0000);
    host_u.wr(8'h1C, 16'h00FF);
    rd_exp(8'h20, 16'hFFFF, 16'h0000);
    $display("test reset and refused access done");
    repeat (4) begin
      gp <= $random(seed);
      host_u.idle(3);
      rd_exp(8'h1C, 16'hFFFF, {8'h00, gp});
    end
    gp <= 8'h00;
    adapter_ref_clock_pin <= 1'b1;
    host_u.idle(6);
    rd_exp(8'h16, 16'h0018, 16'h0008);
    host_u.wr(8'h1E, 16'h0001);
    gp <= 8'h08;
    host_u.idle(6);
    rd_exp(8'h16, 16'h0010, 16'h0010);
    host_u.wr(8'h16, 16'h0018);
    rd_exp(8'h16, 16'h0018, 16'h0000);
    $display("test activity latches done");
    // random port modes and done flags against the and-rule
    repeat (6) begin
      pmode <= 4'($random(seed));
      pdone <= 4'($random(seed));
      host_u.idle(2);
      check({15'h0000, gud}, {15'h0000, (|pmode) && (&(pdone | ~pmode))});
    end
    pmode <= 4'h5;
    pdone <= 4'h1;
    host_u.idle(3);
    wait_bit(1, 1'b0);
    pdone <= 4'h5;
    wait_bit(1, 1'b1);
    rd_exp(8'h16, 16'h0001, 16'h0001);
    host_u.wr(8'h18, 16'h0001);
    host_u.wr(8'h12, 16'h0001);
    wait_bit(0, 1'b0);
    host_u.wr(8'h16, 16'h0000);
    wait_bit(0, 1'b0);
    host_u.wr(8'h16, 16'h0001);
    wait_bit(0, 1'b1);
    host_u.wr(8'h18, 16'h0002);
    unl <= 3'h4 | 3'($random(seed));
    wait_bit(0, 1'b0);
    rd_exp(8'h14, 16'h0003, 16'h0003);
    unl <= 3'h0;
    host_u.wr(8'h16, 16'h0002);
    wait_bit(0, 1'b1);
    $display("test update and lock done");
    host_u.wr(8'h18, 16'h0000);
    host_u.idle(25);
    wait_bit(0, 1'b1);
    rd_exp(8'h16, 16'h0004, 16'h0004);
    host_u.wr(8'h18, 16'h0004);
    wait_bit(0, 1'b0);
    ce <= 1'b0;
    host_u.wr(8'h18, 16'h0000);
    ce <= 1'b1;
    rd_exp(8'h18, 16'hFFFF, 16'h0004);
    host_u.wr(8'h12, 16'h0000);
    wait_bit(0, 1'b1);
    $display("test one second and freeze done");
    host_u.idle(2);
    close_out;
  end
endmodule
